// ===== dv/pmat_cpu_model.sv
// Behavioural CPU issuing monitored memory and I/O cycles
`timescale 1ns/10ps
`default_nettype none
module pmat_cpu_model
  import pmat_pkg::*;
(
  // Clock
  input wire logic clk,
  // Cycle towards the monitor
  output var pmat_cycle_t cycle
);
  initial cycle = '0;
  // One access per call; an idle bus shows the inverted address so a
  // stale decode cannot pass for a real one
  task automatic access(input logic io, input logic [23:0] addr);
    @(posedge clk);
    cycle <= '{1'b1, io, 1'($urandom), 1'b0, addr, 8'($urandom)};
    @(posedge clk);
    cycle <= '{1'b0, 1'b0, 1'b0, 1'b0, ~addr, ~cycle.wdata};
  endtask
endmodule // pmat_cpu_model
`default_nettype wire

// ===== dv/pmat_top_props.sv
// Checker of the activity timer and access event block
`timescale 1ns/10ps
`default_nettype none
module pmat_top_props
  import pmat_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_q,
  // Monitored cycle and doze state
  input wire pmat_cycle_t cycle,
  input wire logic doze_active,
  // Interrupts and clock control
  input wire logic [NPMI-1:0] pmi_q,
  input wire logic doze_exit_q,
  input wire logic cpu_clock_stop_b_q
);
  // ---------------------------------------------------------------
  // Decode sequences
  // ---------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Upper address bits are ignored for I/O, as the bench keeps them 0
  sequence io_s(logic [15:0] lo, logic [15:0] hi);
    cycle.valid && cycle.io && (cycle.addr[15:0] >= lo) &&
      (cycle.addr[15:0] <= hi);
  endsequence
  sequence no_doze_s;
    !doze_active ##1 !doze_active;
  endsequence

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_q == 8'h00)
    else $error("read data outside its window");
  unmapped_rd_a: assert property (reg_rd && reg_addr == 8'h00 |=>
    reg_rdata_q == 8'h00) else $error("unmapped read not zero");
  kbd_event_a: assert property (
    io_s(16'h0060, 16'h0060) or io_s(16'h0064, 16'h0064) |=> pmi_q[14])
    else $error("keyboard access without its interrupt");
  sera_event_a: assert property (
    io_s(16'h03f8, 16'h03ff) |=> pmi_q[21])
    else $error("serial a access without its interrupt");
  serb_event_a: assert property (
    io_s(16'h02f8, 16'h02ff) |=> pmi_q[22])
    else $error("serial b access without its interrupt");
  lpt_quiet_a: assert property (
    io_s(16'h0378, 16'h037f) |=> pmi_q[14:12] == 3'h0)
    else $error("parallel port raised an access interrupt");
  event_cause_a: assert property (
    pmi_q[14] || pmi_q[21] || pmi_q[22] || pmi_q[37] |->
    $past(cycle.valid)) else $error("access interrupt without access");
  doze_exit_a: assert property (doze_exit_q |->
    $past(doze_active) && $past(cycle.valid))
    else $error("doze exit without access in doze");
  stop_idle_a: assert property (no_doze_s |-> cpu_clock_stop_b_q)
    else $error("clock stop outside doze");
  timer_once_a: assert property (pmi_q[9] |=> !pmi_q[9] [*8])
    else $error("disk timer interrupt repeated");
endmodule // pmat_top_props

bind pmat_top pmat_top_props u_props (.clk(clk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
  .cycle(cycle), .doze_active(doze_active), .pmi_q(pmi_q),
  .doze_exit_q(doze_exit_q), .cpu_clock_stop_b_q(cpu_clock_stop_b_q));
`default_nettype wire

// ===== dv/pmat_top_tb_top.sv
// Self-checking bench of the activity timer and access event block
`timescale 1ns/10ps
`default_nettype none
module pmat_top_tb_top
  import pmat_pkg::*;
;
  logic clk, rst_b, reg_wr, reg_rd, sqw, doze, smi_q, doze_exit_q, stop_b;
  logic rd_d, cv_d;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q, v;
  logic [NPMI-1:0] pmi_q;
  logic [39:0] seen;
  logic [39:0] exp_q [$];
  pmat_cycle_t cycle;
  int mismatches = 0, n_tests = 0, cycles = 0, hi;
  logic [23:0] ea [7] = '{24'h60, 24'h64, 24'h3f8, 24'h2ff, 24'h3f5,
    24'h3df, 24'ha0000};
  int ep [7] = '{14, 14, 21, 22, 13, 12, 12};
  int eb [7] = '{2, 2, 5, 6, 1, 0, 0};

  pmat_top dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .cycle(cycle), .ide_pri_hit(1'b0),
    .ide_sec_hit(1'b0), .gnr_hit(8'h00), .general_chip_select_hit(4'h0),
    .square_wave_input(sqw), .doze_active(doze), .pmi_q(pmi_q),
    .smi_q(smi_q), .doze_exit_q(doze_exit_q), .cpu_clock_stop_b_q(stop_b));
  pmat_cpu_model cpu (.clk(clk), .cycle(cycle));

  // ---------------------------------------------------------------
  // Clock, shared tasks and the result monitor
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(string nm, logic [39:0] sn, logic [39:0] ex);
    n_tests++;
    if (sn !== ex) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, ex, sn);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    exp_q.push_back({32'h0, e});
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  // Expected word: interrupts, then system request, then doze exit
  function automatic logic [39:0] ev(int n, logic s, logic d);
    return (40'h1 << (n + 2)) | {38'h0, s, d};
  endfunction
  task automatic acc(logic io, logic [23:0] a, logic [39:0] e);
    exp_q.push_back(e);
    cpu.access(io, a);
  endtask
  // Square wave kept slow enough that every edge is a clean tick
  task automatic sq(int n);
    repeat (n) begin
      @(posedge clk);
      sqw <= 1'b1;
      repeat (4) @(posedge clk);
      sqw <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  always @(posedge clk) begin
    rd_d <= reg_rd;
    cv_d <= cycle.valid;
    cycles++;
    if (cycles == 8000) begin
      mismatches++;
      summarize();
    end
  end
  // Any output pulse takes the oldest note; none pending means spurious
  always @(negedge clk) begin
    if (rst_b && (rd_d || cv_d || pmi_q != '0 || smi_q || doze_exit_q)) begin
      seen = rd_d ? {32'h0, reg_rdata_q} : {pmi_q, smi_q, doze_exit_q};
      if (exp_q.size() == 0) chk("output", seen, 40'h0);
      else chk("output", seen, exp_q.pop_front());
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h6053));
    {rst_b, reg_wr, reg_rd, sqw, doze, rd_d, cv_d} = 7'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    foreach (TMR_OFS[i]) rd(TMR_OFS[i], 8'h00);
    rd(8'h41, 8'h00);
    rd(8'h79, 8'h00);
    wr(8'h00, 8'hff);
    rd(8'h00, 8'h00);
    v = 8'(5 + $urandom_range(250));
    wr(8'h44, v);
    rd(8'h44, v);
    wr(8'h79, 8'hff);
    rd(8'h79, 8'hf7);
    wr(8'h79, 8'h00);
    $display("test registers done");
    foreach (ea[i]) begin
      wr(8'hde, 8'h01 << eb[i]);
      acc(i < 6, ea[i], ev(ep[i], 1'b1, 1'b0));
      wr(8'hde, 8'h00);
      acc(i < 6, ea[i], ev(ep[i], 1'b0, 1'b0));
    end
    $display("test events done");
    wr(8'h57, 8'h20);
    acc(1'b1, 24'h3f5, 40'h0);
    acc(1'b1, 24'h1f0, ev(13, 1'b0, 1'b0));
    wr(8'h57, 8'h10);
    acc(1'b1, 24'h3f6, 40'h0);
    wr(8'h57, 8'h00);
    wr(8'h4e, 8'h20);
    acc(1'b1, 24'h37f, 40'h0);
    wr(8'hf5, 8'h01);
    acc(1'b1, 24'h00f, ev(37, 1'b0, 1'b0));
    wr(8'hf5, 8'h03);
    acc(1'b1, 24'h4ff, ev(37, 1'b1, 1'b0));
    wr(8'hf5, 8'h00);
    acc(1'b1, 24'h000, 40'h0);
    $display("test exclusions done");
    wr(8'h45, 8'h05);
    wr(8'hf6, 8'h02);
    acc(1'b1, 24'h3f5, ev(13, 1'b0, 1'b0));
    sq(2);
    rd(8'h45, 8'h05);
    exp_q.push_back(ev(9, 1'b0, 1'b0));
    sq(2);
    repeat (8) @(posedge clk);
    chk("timer_early", 40'(exp_q.size()), 40'h1);
    sq(1);
    repeat (8) @(posedge clk);
    chk("timer_done", 40'(exp_q.size()), 40'h0);
    sq(8);
    $display("test timer done");
    doze <= 1'b1;
    wr(8'h79, 8'h10);
    wr(8'hf6, 8'h04);
    acc(1'b1, 24'h64, ev(14, 1'b0, 1'b1));
    repeat (4) @(posedge clk);
    chk("clock_stop", {39'h0, stop_b}, 40'h1);
    for (int m = 1; m < 4; m++) begin
      wr(8'h41, 8'(m << 2));
      repeat (40) @(posedge clk);
      hi = 0;
      repeat (32) begin
        @(posedge clk);
        hi += int'(stop_b);
      end
      chk("stop_high", 40'(hi), 40'(32 - 8 * m));
    end
    doze <= 1'b0;
    // Doze timer on its own base: 64 raw edges after an enabled reload
    wr(8'h41, 8'h02);
    acc(1'b1, 24'h64, ev(14, 1'b0, 1'b0));
    exp_q.push_back(ev(27, 1'b0, 1'b0));
    sq(64);
    repeat (8) @(posedge clk);
    chk("doze_timeout", 40'(exp_q.size()), 40'h0);
    $display("test doze done");
    summarize();
  end
endmodule // pmat_top_tb_top
`default_nettype wire

// ===== src/pmat_pkg.sv
// Constants and types of the activity timer and access event block
package pmat_pkg;
  // ---------------------------------------------------------------
  // Widths and counts
  // ---------------------------------------------------------------
  localparam int NTMR = 16;
  localparam int NEV = 10;
  localparam int NCFG = 22;
  localparam int NPMI = 38;
  localparam int DZ_W = 19;
  localparam int SCL_W = 16;
  localparam int MOD_W = 4;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [7:0] ONE8 = 8'h01;

  // ---------------------------------------------------------------
  // Timer indices; the last four are the second general bank
  // ---------------------------------------------------------------
  localparam int T_DISP = 0, T_DISK = 1, T_KBD = 2, T_IDE = 3;
  localparam int T_SERA = 4, T_SERB = 5, T_GNR1 = 6, T_GNR3 = 8;
  localparam int T_IDLE = 10, T_POLL = 11, T_GNR5 = 12;
  localparam int E_IDE = 3;
  localparam logic [7:0] TMR_OFS [NTMR] = '{8'h44, 8'h45, 8'h46,
    8'hb4, 8'hb5, 8'hb6, 8'h47, 8'hb7, 8'he7, 8'he8, 8'h4f, 8'h69,
    8'h47, 8'hb7, 8'he7, 8'he8};
  localparam int TMR_PMI [NTMR] = '{8, 9, 10, 19, 17, 18, 11, 16, 29,
    30, 4, 5, 11, 16, 29, 30};
  localparam int EV_PMI [NEV] = '{12, 13, 14, 23, 21, 22, 15, 20, 31,
    32};
  localparam int PMI_DOZE = 27;
  localparam int PMI_DMA = 37;

  // ---------------------------------------------------------------
  // Configuration registers, index into the config array
  // ---------------------------------------------------------------
  localparam int C_40 = 0, C_41 = 1, C_CS0 = 2, C_43 = 6, C_4E = 7;
  localparam int C_57 = 8, C_5B = 9, C_5F = 10, C_79 = 11, C_AC = 12;
  localparam int C_AE = 13, C_BE = 14, C_D6 = 15, C_DB = 16;
  localparam int C_DE = 17, C_E9 = 18, C_F5 = 19, C_RL0 = 20;
  localparam int C_RL1 = 21;
  localparam logic [7:0] CFG_OFS [NCFG] = '{8'h40, 8'h41, 8'h42,
    8'hb2, 8'h68, 8'he6, 8'h43, 8'h4e, 8'h57, 8'h5b, 8'h5f, 8'h79,
    8'hac, 8'hae, 8'hbe, 8'hd6, 8'hdb, 8'hde, 8'he9, 8'hf5, 8'hf6,
    8'hf7};
  localparam logic [7:0] CFG_RST [NCFG] = '{default: 8'h00};
  localparam logic [7:0] CFG_RMASK [NCFG] = '{11: 8'hf7,
    default: 8'hff};

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int B_DIV4 = 6, B_DZ_SEL = 5, B_DZ_MOD = 2, B_DZ_RL = 1;
  localparam int B_DZ_EXIT = 4, B_IDE_SEC = 2, B_BANK = 7;
  localparam int B_FDD_X = 5, B_HDD_X = 4, B_FDC_ALL = 7;
  localparam int B_VIO_X = 7, B_VMEM_X = 6, B_ISA_X = 7, B_PCI_IN = 6;
  localparam int B_LPT = 5, B_DMA_PMI = 0, B_DMA_SMI = 1, B_DRV = 4;

  // ---------------------------------------------------------------
  // Time bases: square-wave edges per tick, doze limits, stop phases
  // ---------------------------------------------------------------
  localparam int SQ1_BITS = 6, SQ2_BITS = 11, SQ3_BITS = 16;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam logic [DZ_W-1:0] DZ_LIM [8] = '{19'h00040, 19'h00080,
    19'h00100, 19'h00400, 19'h01000, 19'h04000, 19'h10000, 19'h40000};
  localparam logic [MOD_W-1:0] THI_75 = 4'hc, THI_50 = 4'h8;
  localparam logic [MOD_W-1:0] THI_25 = 4'h4, THI_12 = 4'h2;

  // ---------------------------------------------------------------
  // Fixed I/O and memory ranges
  // ---------------------------------------------------------------
  localparam logic [15:0] IO_FDC_DATA = 16'h03f5, IO_HD_LO = 16'h01f0;
  localparam logic [15:0] IO_HD_HI = 16'h01f7, IO_HD_CTL = 16'h03f6;
  localparam logic [15:0] IO_KBD_A = 16'h0060, IO_KBD_B = 16'h0064;
  localparam logic [15:0] IO_VID_LO = 16'h03b0, IO_VID_HI = 16'h03df;
  localparam logic [23:0] MEM_VID_LO = 24'h0a0000;
  localparam logic [23:0] MEM_VID_HI = 24'h0bffff;
  localparam logic [15:0] IO_SERA = 16'h03f8, IO_SERB = 16'h02f8;
  localparam logic [15:0] IO_LPT1 = 16'h0378, IO_LPT2 = 16'h0278;
  localparam logic [15:0] IO_LPT3 = 16'h03b8;
  localparam logic [15:0] IO_DRV_PRI = 16'h01f6, IO_DRV_SEC = 16'h0176;
  localparam logic [15:0] IO_FDC [8] = '{16'h03f2, 16'h03f4, 16'h03f5,
    16'h03f7, 16'h0372, 16'h0374, 16'h0375, 16'h0377};
  localparam logic [15:0] IO_DMA_LO [7] = '{16'h0000, 16'h0400,
    16'h00c0, 16'h04c0, 16'h04e0, 16'h0080, 16'h0480};
  localparam logic [15:0] IO_DMA_HI [7] = '{16'h000f, 16'h040f,
    16'h00df, 16'h04df, 16'h04ff, 16'h008f, 16'h048f};
  localparam logic [15:0] GRP8_MASK = 16'hfff8;

  // One CPU memory or I/O cycle as seen by the monitor
  typedef struct packed {
    logic valid;
    logic io;
    logic write;
    logic local_bus;
    logic [23:0] addr;
    logic [7:0] wdata;
  } pmat_cycle_t;
endpackage

// ===== src/pmat_top.sv
// Activity timers, doze timer and access event logic of the PMU
//
// Operation
// - Doze timer runs on its own selectable base and raises POWER_MGMT_INTERRUPT 27.
// - Doze-reload bit lets enabled non-general events reload doze timer.
// - Access events raise their own POWER_MGMT_INTERRUPT; enables forward it to SYSTEM_MGMT_INTERRUPT.
// - Access events may reload their own timer with the written count.
// - Each event has current-SYSTEM_MGMT_INTERRUPT, next-SYSTEM_MGMT_INTERRUPT and idle-reload enables.
// - Parallel port ranges only reload the idle timer and, with the doze-reload bit, the doze timer, when enabled.
// - Serial A range raises POWER_MGMT_INTERRUPT 21 with its three enables.
// - Serial B range raises POWER_MGMT_INTERRUPT 22 with its three enables.
// - Floppy data and hard disk ranges form disk event, POWER_MGMT_INTERRUPT 13.
// - Keyboard ports 060h and 064h form keyboard event, POWER_MGMT_INTERRUPT 14.
// - Video memory and video I/O form display event, POWER_MGMT_INTERRUPT 12, maskable.
// - Integrated IDE decode, primary or secondary, raises POWER_MGMT_INTERRUPT 23.
// - General ranges one and two raise POWER_MGMT_INTERRUPT 15 and 20.
// - General ranges three and four raise POWER_MGMT_INTERRUPT 31 and 32.
// - DMA controller port groups raise POWER_MGMT_INTERRUPT 37 under a two-bit field.
// - Four chip-select decodes may only reload the idle timer.
// - Floppy counts only when not excluded; a bit widens its ports.
// - Hard disk ranges count only when not excluded, ISA or PCI.
// - Integrated IDE event ignores the hard-disk exclude bit.
// - Latched drive-select bit per cable picks which timer reloads.
// - Zero count disables a timer; a count waits for next access, but the periodic timer starts at once.
// - Timer reads return the written value, periodic timer its count.
// - Timers tick from four square-wave rates, optional divide by four.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module pmat_top
  import pmat_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  // Monitored CPU cycle and external decodes
  input wire pmat_cycle_t cycle,
  input wire logic ide_pri_hit,
  input wire logic ide_sec_hit,
  input wire logic [7:0] gnr_hit,
  input wire logic [3:0] general_chip_select_hit,
  // Time base and doze state
  input wire logic square_wave_input,
  input wire logic doze_active,
  // Interrupts and clock control
  output logic [NPMI-1:0] pmi_q,
  output logic smi_q,
  output logic doze_exit_q,
  output logic cpu_clock_stop_b_q
);
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [7:0] cfg_q [NCFG];
  logic [7:0] preset_q [NTMR];
  logic [7:0] cnt_q [NTMR];
  logic [NTMR-1:0] run_q, to_q, twr, reload;
  logic [3:0] tick;
  logic sqw_q, sq_edge, base;
  logic [1:0] pre_q;
  logic [SCL_W-1:0] scl_q;
  logic [DZ_W-1:0] dz_cnt_q;
  logic dz_run_q, dz_to_q, dz_reload;
  logic [MOD_W-1:0] phase_q, thi;
  logic drv_pri_q, drv_sec_q;
  logic [NEV-1:0] ev, arm_q, cur_en, nxt_en, idl_en, rl_en;
  logic [15:0] ioa;
  logic io_cyc, fdd, hdd, vid, parallel_port, dma, ide_hit, ide_drv;
  logic [NPMI-1:0] pmi_d;
  logic smi_d, bank;

  function automatic logic inr(input logic [15:0] a,
                               input logic [15:0] lo,
                               input logic [15:0] hi);
    inr = (a >= lo) && (a <= hi);
  endfunction

  // ---------------------------------------------------------------
  // Configuration registers and read port
  // ---------------------------------------------------------------
  // Config writes land at their fixed offsets
  always_ff @(posedge clk) begin
    for (int c = 0; c < NCFG; c++) begin
      if (!rst_b) begin
        cfg_q[c] <= CFG_RST[c];
      end else if (reg_wr && reg_addr == CFG_OFS[c]) begin
        cfg_q[c] <= reg_wdata;
      end
    end
  end

  assign bank = cfg_q[C_AE][B_BANK];

  // Timer writes; shared offsets follow the bank select bit
  always_comb begin
    for (int t = 0; t < NTMR; t++) begin
      twr[t] = reg_wr && reg_addr == TMR_OFS[t] &&
               (t < T_GNR1 || t == T_IDLE || t == T_POLL ||
                ((t >= T_GNR5) == bank));
    end
  end

  // Read data stand one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata_q <= ZERO8;
    end else begin
      reg_rdata_q <= ZERO8;
      if (reg_rd) begin
        for (int c = 0; c < NCFG; c++) begin
          if (reg_addr == CFG_OFS[c]) begin
            reg_rdata_q <= cfg_q[c] & CFG_RMASK[c];
          end
        end
        for (int t = 0; t < NTMR; t++) begin
          if (reg_addr == TMR_OFS[t] &&
              (t < T_GNR1 || t == T_IDLE || t == T_POLL ||
               ((t >= T_GNR5) == bank))) begin
            reg_rdata_q <= (t == T_POLL) ? cnt_q[t] : preset_q[t];
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Square-wave time base
  // ---------------------------------------------------------------
  // The input is already synchronous, so one flop finds the edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sqw_q <= 1'b0;
      pre_q <= 2'h0;
      scl_q <= '0;
    end else begin
      sqw_q <= square_wave_input;
      if (sq_edge) begin
        pre_q <= pre_q + 2'h1;
      end
      if (base) begin
        scl_q <= scl_q + 1'b1;
      end
    end
  end

  assign sq_edge = square_wave_input && !sqw_q;
  assign base = sq_edge && (!cfg_q[C_40][B_DIV4] || pre_q == DIV4_LAST);
  // Four rates: full, /64, /2048, /65536 of the base
  assign tick[0] = base;
  assign tick[1] = base && (&scl_q[SQ1_BITS-1:0]);
  assign tick[2] = base && (&scl_q[SQ2_BITS-1:0]);
  assign tick[3] = base && (&scl_q[SQ3_BITS-1:0]);

  // ---------------------------------------------------------------
  // Access event decode
  // ---------------------------------------------------------------
  assign ioa = cycle.addr[15:0];
  assign io_cyc = cycle.valid && cycle.io;

  always_comb begin
    fdd = 1'b0;
    for (int k = 0; k < 8; k++) begin
      if (cfg_q[C_D6][B_FDC_ALL] && ioa == IO_FDC[k]) begin
        fdd = 1'b1;
      end
    end
    fdd = io_cyc && !cfg_q[C_57][B_FDD_X] &&
          (fdd || ioa == IO_FDC_DATA);
    dma = 1'b0;
    for (int k = 0; k < 7; k++) begin
      if (inr(ioa, IO_DMA_LO[k], IO_DMA_HI[k])) begin
        dma = io_cyc;
      end
    end
  end

  // ISA and PCI disk cycles both count
  assign hdd = io_cyc && !cfg_q[C_57][B_HDD_X] &&
               (inr(ioa, IO_HD_LO, IO_HD_HI) || ioa == IO_HD_CTL);
  // Video ranges each maskable; bus of origin gated as well
  assign vid = cycle.valid &&
    ((cycle.io && !cfg_q[C_43][B_VIO_X] &&
      inr(ioa, IO_VID_LO, IO_VID_HI)) ||
     (!cycle.io && !cfg_q[C_43][B_VMEM_X] &&
      cycle.addr >= MEM_VID_LO && cycle.addr <= MEM_VID_HI)) &&
    (cycle.local_bus ? cfg_q[C_5F][B_PCI_IN] : !cfg_q[C_5F][B_ISA_X]);
  assign parallel_port = io_cyc && ((ioa & GRP8_MASK) == IO_LPT1 ||
    (ioa & GRP8_MASK) == IO_LPT2 || (ioa & GRP8_MASK) == IO_LPT3);
  // Integrated decode only; disk exclude bits play no part here
  assign ide_hit = cycle.valid &&
    (cfg_q[C_AC][B_IDE_SEC] ? ide_sec_hit : ide_pri_hit);
  assign ide_drv = cfg_q[C_AC][B_IDE_SEC] ? drv_sec_q : drv_pri_q;

  // Event vector in timer order
  assign ev[T_DISP] = vid;
  assign ev[T_DISK] = fdd || hdd;
  assign ev[T_KBD] = io_cyc && (ioa == IO_KBD_A || ioa == IO_KBD_B);
  assign ev[E_IDE] = ide_hit;
  assign ev[T_SERA] = io_cyc && (ioa & GRP8_MASK) == IO_SERA;
  assign ev[T_SERB] = io_cyc && (ioa & GRP8_MASK) == IO_SERB;
  assign ev[NEV-1:T_GNR1] = cycle.valid ? gnr_hit[3:0] : 4'h0;

  // Enable vectors gathered from the event registers
  assign cur_en = {cfg_q[C_E9][3], cfg_q[C_E9][1], cfg_q[C_DE][4],
    cfg_q[C_DE][3], cfg_q[C_DE][6], cfg_q[C_DE][5], cfg_q[C_DE][7],
    cfg_q[C_DE][2], cfg_q[C_DE][1], cfg_q[C_DE][0]};
  assign nxt_en = {cfg_q[C_E9][2], cfg_q[C_E9][0], cfg_q[C_DB][0],
    cfg_q[C_5B][3], cfg_q[C_DB][2], cfg_q[C_DB][1], cfg_q[C_DB][3],
    cfg_q[C_5B][2], cfg_q[C_5B][1], cfg_q[C_5B][0]};
  assign idl_en = {cfg_q[C_BE][1], cfg_q[C_4E][4], cfg_q[C_BE][3],
    cfg_q[C_4E][3], cfg_q[C_BE][5], cfg_q[C_BE][4], cfg_q[C_BE][2],
    cfg_q[C_4E][2], cfg_q[C_4E][1], cfg_q[C_4E][0]};
  assign rl_en = {cfg_q[C_RL1][1:0], cfg_q[C_RL0]};

  // Latch drive-select bit on writes to each cable's drive/head port
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      drv_pri_q <= 1'b0;
      drv_sec_q <= 1'b0;
    end else if (io_cyc && cycle.write) begin
      if (ioa == IO_DRV_PRI) begin
        drv_pri_q <= cycle.wdata[B_DRV];
      end
      if (ioa == IO_DRV_SEC) begin
        drv_sec_q <= cycle.wdata[B_DRV];
      end
    end
  end

  // ---------------------------------------------------------------
  // Timer reload routing
  // ---------------------------------------------------------------
  always_comb begin
    reload = '0;
    for (int e = 0; e < NEV; e++) begin
      if (e != E_IDE) begin
        reload[e] = ev[e] && rl_en[e];
      end
    end
    // Second drive on the cable steers to another timer
    reload[T_IDE] = ev[E_IDE] && rl_en[E_IDE] && !ide_drv;
    reload[T_GNR3] = reload[T_GNR3] ||
                     (ev[E_IDE] && rl_en[E_IDE] && ide_drv);
    reload[T_IDLE] = |(ev & idl_en) ||
      (parallel_port && cfg_q[C_4E][B_LPT]) ||
      (cycle.valid && |(general_chip_select_hit & {cfg_q[C_BE][7:6],
                                    cfg_q[C_4E][7:6]}));
    for (int g = 0; g < 4; g++) begin
      reload[T_GNR5 + g] = cycle.valid && gnr_hit[4 + g];
    end
  end

  // ---------------------------------------------------------------
  // Countdown timers
  // ---------------------------------------------------------------
  for (genvar i = 0; i < NTMR; i++) begin : g_tmr
    logic [1:0] sel;
    assign sel = cfg_q[C_CS0 + i / 4][(i % 4) * 2 +: 2];
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        preset_q[i] <= ZERO8;
        cnt_q[i] <= ZERO8;
        run_q[i] <= 1'b0;
        to_q[i] <= 1'b0;
      end else begin
        to_q[i] <= 1'b0;
        if (twr[i]) begin
          // A write presets only; the periodic timer starts at once
          preset_q[i] <= reg_wdata;
          cnt_q[i] <= reg_wdata;
          run_q[i] <= (i == T_POLL) && reg_wdata != ZERO8;
        end else if (reload[i] && preset_q[i] != ZERO8) begin
          cnt_q[i] <= preset_q[i];
          run_q[i] <= 1'b1;
        end else if (run_q[i] && tick[sel]) begin
          if (cnt_q[i] == ONE8) begin
            to_q[i] <= 1'b1;
            cnt_q[i] <= (i == T_POLL) ? preset_q[i] : ZERO8;
            run_q[i] <= (i == T_POLL);
          end else begin
            cnt_q[i] <= cnt_q[i] - ONE8;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Doze timer and clock-stop modulation
  // ---------------------------------------------------------------
  // General-range and chip-select events never reload doze
  assign dz_reload = cfg_q[C_41][B_DZ_RL] &&
    (|(ev[T_SERB:0] & rl_en[T_SERB:0]) ||
     (parallel_port && cfg_q[C_4E][B_LPT]));

  // Counts raw square-wave edges, not the shared rate taps
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dz_cnt_q <= '0;
      dz_run_q <= 1'b0;
      dz_to_q <= 1'b0;
    end else begin
      dz_to_q <= 1'b0;
      if (dz_reload) begin
        dz_cnt_q <= '0;
        dz_run_q <= 1'b1;
      end else if (dz_run_q && sq_edge) begin
        if (dz_cnt_q + 1'b1 ==
            DZ_LIM[cfg_q[C_41][B_DZ_SEL +: 3]]) begin
          dz_to_q <= 1'b1;
          dz_run_q <= 1'b0;
          dz_cnt_q <= '0;
        end else begin
          dz_cnt_q <= dz_cnt_q + 1'b1;
        end
      end
    end
  end

  // High time within a 16-clock period; wider codes use the shortest
  always_comb begin
    case (cfg_q[C_41][B_DZ_MOD +: 3])
      3'h1: thi = THI_75;
      3'h2: thi = THI_50;
      3'h3: thi = THI_25;
      default: thi = THI_12;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      phase_q <= '0;
      cpu_clock_stop_b_q <= 1'b1;
    end else begin
      phase_q <= phase_q + 1'b1;
      cpu_clock_stop_b_q <= !(doze_active &&
        cfg_q[C_41][B_DZ_MOD +: 3] != 3'h0 && phase_q >= thi);
    end
  end

  // ---------------------------------------------------------------
  // POWER_MGMT_INTERRUPT, SYSTEM_MGMT_INTERRUPT and doze exit
  // ---------------------------------------------------------------
  always_comb begin
    pmi_d = '0;
    for (int t = 0; t < NTMR; t++) begin
      pmi_d[TMR_PMI[t]] = pmi_d[TMR_PMI[t]] || to_q[t];
    end
    for (int e = 0; e < NEV; e++) begin
      pmi_d[EV_PMI[e]] = ev[e];
    end
    pmi_d[PMI_DOZE] = dz_to_q;
    pmi_d[PMI_DMA] = dma && cfg_q[C_F5][B_DMA_PMI];
  end

  // Current access fires now; next access arms and fires later
  assign smi_d = |(ev & cur_en) || |(ev & arm_q) ||
                 (dma && cfg_q[C_F5][B_DMA_SMI]);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      arm_q <= '0;
      pmi_q <= '0;
      smi_q <= 1'b0;
      doze_exit_q <= 1'b0;
    end else begin
      arm_q <= (arm_q & ~ev) | (ev & nxt_en);
      pmi_q <= pmi_d;
      smi_q <= smi_d;
      // Reload-only events wake from doze without any SYSTEM_MGMT_INTERRUPT
      doze_exit_q <= cfg_q[C_79][B_DZ_EXIT] && doze_active &&
        |(ev & rl_en & ~cur_en & ~nxt_en);
    end
  end
endmodule // pmat_top
`default_nettype wire
